// ### verif/enc_model.sv
// gray encoder and programming release switch model
`timescale 1ns/1ps
module enc_model
  import cam_pkg::*;
(
  input  wire logic [POS_W-1:0] pos,
  input  wire logic             rel,
  output logic      [POS_W-1:0] enc_gray,
  output logic                  prog_release
);
  // gray code so only one pin changes per step, except at the wrap from 359 to 0
  assign enc_gray     = pos ^ (pos >> 1);
  assign prog_release = rel;
endmodule // enc_model

// ### verif/testbench.sv
// self-checking bench of the cam switch core
`timescale 1ns/1ps
module testbench
  import cam_pkg::*;
;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        rel = 1'b0;
  logic [8:0]  pos = 9'h000;
  bus_req_t    bus_req = '0;
  logic [3:0]  node = 4'h5;
  logic [31:0] rd_data;
  logic [15:0] cam_out;
  logic        pend_on, pend_off, erase_busy, prompt, rd_seen = 1'b0;
  logic [8:0]  enc_gray;
  logic        prog_release;
  logic [31:0] expq[$];
  int          num_errors = 0, tests_run = 0, seed = 30469, pi, zi;
  always #4 clk = ~clk;
  enc_model u_enc_model (.pos(pos), .rel(rel), .enc_gray(enc_gray),
    .prog_release(prog_release));
  // short speed window keeps the run brief
  cam_switch_programming_core #(.SPEED_WIN_CYC(50))
    u_cam_switch_programming_core (.clk(clk), .rst_n(rst_n),
    .enc_gray(enc_gray), .prog_release(prog_release),
    .network_node_number(node), .bus_req(bus_req), .rd_data(rd_data),
    .cam_out(cam_out), .pend_on(pend_on), .pend_off(pend_off),
    .erase_busy(erase_busy), .erase_everything_prompt(prompt));
  //////////////////////////////////////////////////////////////////////
  task report(input logic [31:0] a, input logic [31:0] e);
    tests_run++;
    if (a !== e)
    begin
      num_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, a, e);
    end
  endtask
  task cmp_rd(input logic [31:0] a, input logic [31:0] e);
    report(a, e);
  endtask
  task cmp_out(input logic a, input logic e);
    report({31'h0, a}, {31'h0, e});
  endtask
  task wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk) bus_req <= '{1'b1, 1'b0, a, d};
    @(posedge clk) bus_req <= '0;
  endtask
  task rd(input logic [3:0] a, input logic [31:0] e);
    expq.push_back(e);
    @(posedge clk) bus_req <= '{1'b0, 1'b1, a, 32'h0};
    @(posedge clk) bus_req <= '0;
  endtask
  task cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task done(input string s);
    $display("test %s done", s);
  endtask
  task results;
    // a read whose answer was never compared counts against the run
    if (expq.size() != 0)
      num_errors++;
    $display("compares %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////
  // read data stands only in the cycle after the read strobe
  always @(posedge clk)
  begin
    if (rd_seen)
      cmp_rd(rd_data, expq.pop_front());
    rd_seen = bus_req.rd;
  end
  initial
  begin
    #500000;
    num_errors++;
    results;
  end
  initial
  begin
    cyc(5);
    rst_n <= 1'b1;
    rd(A_CTRL, 32'h20);
    rd(A_SCALE, 32'h3c);
    rd(A_ZERO, 32'h0);
    done("reset");
    for (int i = 0; i < 4; i++)
    begin
      pi = $unsigned($random(seed)) % 360;
      zi = $unsigned($random(seed)) % 360;
      pos <= 9'(pi);
      wr(A_ZERO, 32'(zi));
      cyc(4);
      rd(A_POS, 32'((pi + 360 - zi) % 360));
    end
    wr(A_SCALE, 32'(SCALE_MAX));
    wr(A_SCALE, 32'h2710);
    rd(A_SCALE, 32'(SCALE_MAX));
    done("position");
    wr(A_ZERO, 32'h0);
    pos <= 9'h64;
    wr(A_CMD, 32'(C_EDIT));
    rd(A_CMD, 32'h1);
    rel <= 1'b1;
    cyc(4);
    wr(A_CMD, 32'(C_EDIT));
    cyc(2);
    cmp_out(pend_on, 1'b1);
    wr(A_CMD, 32'(C_TEACH));
    rd(A_VAL, 32'h64);
    wr(A_CMD, 32'(C_CONFIRM));
    cyc(2);
    cmp_out(pend_off, 1'b1);
    wr(A_VAL, 32'h78);
    wr(A_CMD, 32'(C_CONFIRM));
    wr(A_CMD, 32'(C_CANCEL));
    wr(A_SEL, 32'h0);
    rd(A_CAM, 32'h8078_0064);
    pos <= 9'h6e;
    cyc(4200);
    cmp_out(cam_out[0], 1'b1);
    pos <= 9'hc8;
    cyc(4200);
    cmp_out(cam_out[0], 1'b0);
    done("cam");
    wr(A_CMD, 32'(C_SHIFT));
    rd(A_CMD, 32'h8);
    rd(A_VAL, 32'h0);
    wr(A_VAL, 32'h15e);
    wr(A_CMD, 32'(C_CONFIRM));
    cyc(2100);
    rd(A_CMD, 32'h1);
    rd(A_CAM, 32'h806e_005a);
    done("shift");
    wr(A_CMD, 32'(C_EDIT));
    wr(A_VAL, 32'h6e);
    wr(A_CMD, 32'(C_CONFIRM));
    rd(A_CAM, 32'h006e_006e);
    rd(A_CMD, 32'h1);
    done("remove");
    wr(A_CMD, 32'(C_IDLE));
    wr(A_VAL, 32'h5);
    rd(A_VAL, 32'h5);
    wr(A_CMD, 32'(C_CANCEL));
    wr(A_CMD, 32'(C_IDLE));
    rd(A_VAL, 32'h0);
    wr(A_VAL, 32'h7);
    wr(A_CMD, 32'(C_CONFIRM));
    wr(A_CMD, 32'(C_IDLE));
    rd(A_VAL, 32'h7);
    wr(A_CMD, 32'(C_CANCEL));
    done("idle");
    wr(A_CMD, 32'(C_DIR));
    wr(A_VAL, 32'h1);
    wr(A_CMD, 32'(C_CONFIRM));
    wr(A_CMD, 32'(C_DIR));
    wr(A_VAL, 32'h0);
    wr(A_CMD, 32'(C_CANCEL));
    rd(A_CTRL, 32'ha0);
    rd(A_POS, 32'h9f);
    wr(A_ZERO, 32'ha);
    wr(A_CTRL, 32'h60);
    cyc(2);
    rd(A_POS, 32'h9f);
    wr(A_CTRL, 32'h0);
    rd(A_CTRL, 32'ha0);
    rd(A_POS, 32'h95);
    done("direction");
    wr(A_CMD, 32'(C_CLEAR));
    cyc(2);
    cmp_out(prompt, 1'b1);
    wr(A_CMD, 32'(C_CONFIRM));
    cyc(2);
    cmp_out(erase_busy, 1'b1);
    cyc(2100);
    rd(A_CMD, 32'h1);
    rd(A_CAM, 32'h0);
    rd(A_OUT, 32'h0005_0000);
    rd(A_CTRL, 32'h20);
    cyc(3);
    done("clear");
    results;
  end
endmodule // testbench

// ### verilog/cam_pkg.sv
// constants, register map and types of the cam switch programming core
package cam_pkg;
  localparam int          POS_W             = 9;
  localparam logic [8:0]  RES               = 9'h168;
  localparam logic [8:0]  RES_M1            = 9'h167;
  localparam logic [8:0]  RES_HALF          = 9'hb4;
  localparam int          NCAM              = 2000;
  localparam int          CAM_AW            = 11;
  localparam logic [10:0] CAM_LAST          = 11'h7cf;
  localparam int          NIDLE             = 256;
  localparam logic [9:0]  IDLE_MAX          = 10'h3e7;
  localparam logic [13:0] SCALE_MAX         = 14'h270f;
  localparam logic [13:0] SCALE_DEF         = 14'h03c;
  localparam logic [8:0]  ZERO_DEF          = 9'h000;
  localparam logic        DIR_DEF           = 1'b0;
  localparam logic [1:0]  MODE_BLOCK        = 2'h1;
  localparam logic [1:0]  MODE_BIT          = 2'h2;
  localparam logic [1:0]  MODE_SPLIT        = 2'h3;
  localparam logic [1:0]  MODE_DEF          = MODE_BIT;
  localparam int          CLK_MHZ           = 125;
  localparam int          SPEED_WIN_US      = 1000;
  localparam int          SPEED_WIN_CYC_DEF = CLK_MHZ * SPEED_WIN_US;
  localparam logic [9:0]  WINS_PER_S        = 10'h3e8;
  // register indices
  localparam logic [3:0]  A_CTRL  = 4'h0;
  localparam logic [3:0]  A_ZERO  = 4'h1;
  localparam logic [3:0]  A_SCALE = 4'h2;
  localparam logic [3:0]  A_SEL   = 4'h3;
  localparam logic [3:0]  A_CMD   = 4'h4;
  localparam logic [3:0]  A_VAL   = 4'h5;
  localparam logic [3:0]  A_POS   = 4'h6;
  localparam logic [3:0]  A_SPEED = 4'h7;
  localparam logic [3:0]  A_OUT   = 4'h8;
  localparam logic [3:0]  A_CAM   = 4'h9;
  // field positions
  localparam int          CTRL_MODE_LSB = 4;
  localparam int          CTRL_INCR_BIT = 6;
  localparam int          SEL_OUT_LSB   = 4;
  localparam int          SEL_CUR_LSB   = 8;
  // operator commands
  localparam logic [3:0]  C_EDIT    = 4'h1;
  localparam logic [3:0]  C_TEACH   = 4'h2;
  localparam logic [3:0]  C_CONFIRM = 4'h3;
  localparam logic [3:0]  C_CANCEL  = 4'h4;
  localparam logic [3:0]  C_SHIFT   = 4'h5;
  localparam logic [3:0]  C_IDLE    = 4'h6;
  localparam logic [3:0]  C_DIR     = 4'h7;
  localparam logic [3:0]  C_CLEAR   = 4'h8;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [3:0]  addr;
    logic [31:0] wdata;
  } bus_req_t;

  typedef struct packed {
    logic       valid;
    logic [3:0] prog;
    logic [3:0] out;
    logic [8:0] on;
    logic [8:0] off;
  } cam_t;

  typedef struct packed {
    logic       valid;
    logic [9:0] ms;
  } idle_t;

  typedef enum logic [8:0] {
    S_SHOW  = 9'h001,
    S_ON    = 9'h002,
    S_OFF   = 9'h004,
    S_SHIFT = 9'h008,
    S_SRUN  = 9'h010,
    S_IDLE  = 9'h020,
    S_DIR   = 9'h040,
    S_ASK   = 9'h080,
    S_ERASE = 9'h100
  } state_t;
endpackage

// ### verilog/cam_switch_programming_core.sv
// cam switch core: encoder path, cam tables, idle compensation, menu
//
// Contract
// - new cams only from an empty slot
// - turn-on first, then turn-off, shown pending
// - teach loads live position, still adjustable
// - shift needs release, amount starts zero
// - shift amount non-negative, modulo resolution
// - confirm shifts output cams, cancel discards
// - clear all erases, shows busy, restarts
// - idle time advances switching with speed
// - program 0 idle time is default
// - inherited idle time overridable, not removable
// - edited idle acts live; cancel restores
// - compensation modes blockwise, bitwise, split
// - direction 0 normal default, 1 inverted
// - direction edit needs release; confirm stores
// - zero offset subtracted before cam evaluation
// - zero offset ignored for incremental encoder
// - speed scale 0 to 9999, default 60
// - parallel gray absolute encoder, 360 steps
// - node number from switches, not writable
// - equal on and off removes the cam
//
// The register addresses and the strobed register port were decided locally.
`timescale 1ns/1ps
module cam_switch_programming_core
  import cam_pkg::*;
#(
  parameter int SPEED_WIN_CYC = SPEED_WIN_CYC_DEF
)
(
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic [POS_W-1:0] enc_gray,
  input  wire logic             prog_release,
  input  wire logic [3:0]       network_node_number,
  input  wire bus_req_t         bus_req,
  output logic      [31:0]      rd_data,
  output logic      [15:0]      cam_out,
  output logic                  pend_on,
  output logic                  pend_off,
  output logic                  erase_busy,
  output logic                  erase_everything_prompt
);

  cam_t             cams [NCAM];
  idle_t            idle [NIDLE];
  state_t           state;
  logic [POS_W-1:0] gray_m, gray_s, bin, lin, dpos, pos, last_pos;
  logic             rel_m, rel_s, dir, incr, dir_pend, is_new;
  logic [3:0]       node_m, node_s, act_prog, sel_prog, sel_out, cmd;
  logic [1:0]       mode;
  logic [8:0]       zero, shift_amt, edit_on, fwd, steps, step_acc;
  logic [8:0]       spd_ms, on_c, off_c;
  logic [13:0]      scale;
  logic [9:0]       edit_val, wv, sec_cnt;
  logic [10:0]      cursor, run_i, scan_i;
  logic [19:0]      win_cnt;
  logic [31:0]      disp_acc, next_disp, div_num, div_q, speed_disp;
  logic [15:0]      scan_acc, next_acc;
  logic [7:0]       edit_idx;
  logic             win_tick, sec_end, div_run, hit, nxt_free;
  logic             cmd_go, val_go, confirm, cancel, teach, restart;
  logic             cam_we, idle_we;
  logic [10:0]      cam_wa;
  logic [7:0]       idle_wa;
  cam_t             cam_wd, shown, e;
  idle_t            idle_wd, idle_bak;

  function automatic logic [8:0] wsub(input logic [8:0] a,
                                      input logic [8:0] b);
    wsub = (a >= b) ? a - b : a + (RES - b);
  endfunction

  function automatic logic [8:0] wadd(input logic [8:0] a,
                                      input logic [8:0] b);
    logic [9:0] s;
    s = {1'b0, a} + {1'b0, b};
    wadd = (s >= {1'b0, RES}) ? 9'(s - {1'b0, RES}) : s[8:0];
  endfunction

  function automatic logic [3:0] slot_of(input logic [1:0] m,
                                         input logic [3:0] o,
                                         input logic       offs);
    case (m)
      MODE_BIT:   slot_of = o;
      MODE_SPLIT: slot_of = {2'h0, o[3], offs};
      default:    slot_of = {3'h0, o[3]};
    endcase
  endfunction

  // explicit entry wins, program 0 entry is the fallback
  function automatic logic [9:0] eff_idle(input logic [3:0] p,
                                          input logic [3:0] s);
    if (idle[{p, s}].valid)
      eff_idle = idle[{p, s}].ms;
    else if (idle[{4'h0, s}].valid)
      eff_idle = idle[{4'h0, s}].ms;
    else
      eff_idle = 10'h000;
  endfunction

  // advance in steps = steps per window times idle milliseconds
  function automatic logic [8:0] adv_of(input logic [9:0] ms);
    logic [18:0] p;
    p = 19'(spd_ms) * 19'(ms);
    adv_of = (p >= 19'(RES)) ? RES_M1 : p[8:0];
  endfunction

  ////////////////////////////////////////////////////////////////////
  // pin synchronisers and position path
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      gray_m <= '0;
      gray_s <= '0;
      rel_m  <= 1'b0;
      rel_s  <= 1'b0;
      node_m <= '0;
      node_s <= '0;
    end
    else
    begin
      gray_m <= enc_gray;
      gray_s <= gray_m;
      rel_m  <= prog_release;
      rel_s  <= rel_m;
      node_m <= network_node_number;
      node_s <= node_m;
    end
  end

  for (genvar gi = 0; gi < POS_W; gi++)
  begin : g_gray
    assign bin[gi] = ^gray_s[POS_W-1:gi];
  end

  always_comb
  begin
    lin  = (bin >= RES) ? bin - RES : bin;
    dpos = dir ? RES_M1 - lin : lin;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      pos <= '0;
    else
      pos <= incr ? dpos : wsub(dpos, zero);
  end

  ////////////////////////////////////////////////////////////////////
  // speed measurement and scaled display
  assign fwd       = wsub(pos, last_pos);
  assign steps     = (fwd > RES_HALF) ? RES - fwd : fwd;
  assign win_tick  = (win_cnt == 20'(SPEED_WIN_CYC - 1));
  assign sec_end   = win_tick && (sec_cnt == WINS_PER_S - 10'h001);
  assign next_disp = disp_acc + 32'(steps) * 32'(scale);

  // step count per window does not saturate; beyond any real speed
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      last_pos <= '0;
      win_cnt  <= '0;
      step_acc <= '0;
      spd_ms   <= '0;
    end
    else
    begin
      last_pos <= pos;
      win_cnt  <= win_tick ? '0 : win_cnt + 20'h00001;
      step_acc <= win_tick ? steps : step_acc + steps;
      if (win_tick)
        spd_ms <= step_acc;
    end
  end

  // dividing by the resolution by subtraction is slow but cheap
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sec_cnt    <= '0;
      disp_acc   <= '0;
      div_num    <= '0;
      div_q      <= '0;
      div_run    <= 1'b0;
      speed_disp <= '0;
    end
    else
    begin
      if (win_tick)
        sec_cnt <= sec_end ? '0 : sec_cnt + 10'h001;
      disp_acc <= sec_end ? '0 : next_disp;
      if (sec_end)
      begin
        div_num <= next_disp;
        div_q   <= '0;
        div_run <= 1'b1;
      end
      else if (div_run && div_num >= 32'(RES))
      begin
        div_num <= div_num - 32'(RES);
        div_q   <= div_q + 32'h1;
      end
      else if (div_run)
      begin
        speed_disp <= div_q;
        div_run    <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // cam scan: one table entry per clock, outputs renewed per pass
  always_comb
  begin
    e     = cams[scan_i];
    on_c  = wsub(e.on, adv_of(eff_idle(act_prog,
                                       slot_of(mode, e.out, 1'b0))));
    off_c = wsub(e.off, adv_of(eff_idle(act_prog,
                                        slot_of(mode, e.out, 1'b1))));
    hit   = 1'b0;
    if (e.valid && e.prog == act_prog)
      hit = (on_c <= off_c) ? (pos >= on_c && pos < off_c)
                            : (pos >= on_c || pos < off_c);
    next_acc = scan_acc | (16'(hit) << e.out);
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      scan_i   <= '0;
      scan_acc <= '0;
      cam_out  <= '0;
    end
    else if (scan_i == CAM_LAST)
    begin
      scan_i   <= '0;
      scan_acc <= '0;
      cam_out  <= next_acc;
    end
    else
    begin
      scan_i   <= scan_i + 11'h001;
      scan_acc <= next_acc;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // operator menu
  assign cmd      = bus_req.wdata[3:0];
  assign wv       = bus_req.wdata[9:0];
  assign cmd_go   = bus_req.wr && bus_req.addr == A_CMD;
  assign val_go   = bus_req.wr && bus_req.addr == A_VAL;
  assign confirm  = cmd_go && cmd == C_CONFIRM;
  assign cancel   = cmd_go && cmd == C_CANCEL;
  assign teach    = cmd_go && cmd == C_TEACH;
  assign shown    = cams[cursor];
  assign nxt_free = cursor != CAM_LAST && !cams[cursor + 11'h001].valid;
  assign edit_idx = {sel_prog, slot_of(mode, sel_out, sel_out[0])};
  assign restart  = state == S_ERASE && run_i == CAM_LAST;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state     <= S_SHOW;
      cursor    <= '0;
      sel_prog  <= '0;
      sel_out   <= '0;
      edit_val  <= '0;
      edit_on   <= '0;
      is_new    <= 1'b0;
      shift_amt <= '0;
      idle_bak  <= '0;
      dir_pend  <= DIR_DEF;
      run_i     <= '0;
    end
    else
    begin
      if (state == S_SHOW && bus_req.wr && bus_req.addr == A_SEL)
      begin
        sel_prog <= bus_req.wdata[3:0];
        sel_out  <= bus_req.wdata[SEL_OUT_LSB +: 4];
        if (bus_req.wdata[SEL_CUR_LSB +: CAM_AW] <= CAM_LAST)
          cursor <= bus_req.wdata[SEL_CUR_LSB +: CAM_AW];
      end
      if (state == S_ON || state == S_OFF)
      begin
        if (val_go && wv < 10'(RES))
          edit_val <= wv;
        if (teach)
          edit_val <= 10'(pos);
        if (cancel)
          state <= S_SHOW;
      end
      case (state)
        S_SHOW:
          if (cmd_go && rel_s)
            case (cmd)
              C_EDIT:
              begin
                state    <= S_ON;
                is_new   <= !shown.valid;
                edit_val <= shown.valid ? 10'(shown.on) : '0;
              end
              C_SHIFT:
              begin
                state     <= S_SHIFT;
                shift_amt <= '0;
              end
              C_IDLE:
              begin
                state    <= S_IDLE;
                idle_bak <= idle[edit_idx];
                edit_val <= idle[edit_idx].ms;
              end
              C_DIR:
              begin
                state    <= S_DIR;
                dir_pend <= dir;
              end
              C_CLEAR:
                state <= S_ASK;
              default:
                state <= S_SHOW;
            endcase
          else if (cmd_go && cmd == C_CLEAR)
            state <= S_ASK;
        S_ON:
          if (confirm)
          begin
            edit_on  <= edit_val[8:0];
            edit_val <= is_new ? edit_val : 10'(shown.off);
            state    <= (!is_new && edit_val[8:0] == shown.off) ?
                        S_SHOW : S_OFF;
          end
        S_OFF:
          if (confirm && is_new && nxt_free)
          begin
            cursor <= cursor + 11'h001;
            state  <= S_ON;
          end
          else if (confirm)
            state <= S_SHOW;
        S_SHIFT:
        begin
          if (val_go && wv < 10'(RES))
            shift_amt <= wv[8:0];
          if (confirm)
            run_i <= '0;
          if (confirm)
            state <= S_SRUN;
          else if (cancel)
            state <= S_SHOW;
        end
        S_SRUN, S_ERASE:
        begin
          run_i <= run_i + 11'h001;
          if (run_i == CAM_LAST)
            state <= S_SHOW;
          if (restart)
          begin
            cursor   <= '0;
            sel_prog <= '0;
            sel_out  <= '0;
          end
        end
        S_IDLE:
        begin
          if (val_go && wv <= IDLE_MAX)
            edit_val <= wv;
          if (confirm || cancel)
            state <= S_SHOW;
        end
        S_DIR:
        begin
          if (val_go)
            dir_pend <= bus_req.wdata[0];
          if (confirm || cancel)
            state <= S_SHOW;
        end
        S_ASK:
          if (confirm)
          begin
            run_i <= '0;
            state <= S_ERASE;
          end
          else if (cancel)
            state <= S_SHOW;
        default:
          state <= S_SHOW;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  // table writes
  always_comb
  begin
    cam_we = 1'b0;
    cam_wa = cursor;
    cam_wd = shown;
    case (state)
      S_ON:
        if (confirm && !is_new)
        begin
          cam_we       = 1'b1;
          cam_wd.on    = edit_val[8:0];
          cam_wd.valid = edit_val[8:0] != shown.off;
        end
      S_OFF:
        if (confirm)
        begin
          cam_we     = 1'b1;
          cam_wd.off = edit_val[8:0];
          if (is_new)
          begin
            cam_wd.on   = edit_on;
            cam_wd.prog = sel_prog;
            cam_wd.out  = sel_out;
          end
          cam_wd.valid = cam_wd.on != edit_val[8:0];
        end
      S_SRUN:
      begin
        cam_wa     = run_i;
        cam_wd     = cams[run_i];
        cam_we     = cam_wd.valid && cam_wd.prog == sel_prog &&
                     cam_wd.out == sel_out;
        cam_wd.on  = wadd(cam_wd.on, shift_amt);
        cam_wd.off = wadd(cam_wd.off, shift_amt);
      end
      S_ERASE:
      begin
        cam_wa = run_i;
        cam_we = 1'b1;
        cam_wd = '0;
      end
      default:
        cam_we = 1'b0;
    endcase
  end

  always_comb
  begin
    idle_we = 1'b0;
    idle_wa = edit_idx;
    idle_wd = '0;
    if (state == S_IDLE && val_go && wv <= IDLE_MAX)
    begin
      idle_we       = 1'b1;
      idle_wd.ms    = wv;
      idle_wd.valid = wv != 10'h000;
    end
    else if (state == S_IDLE && cancel)
    begin
      idle_we = 1'b1;
      idle_wd = idle_bak;
    end
    else if (state == S_ERASE)
    begin
      idle_we = run_i < 11'(NIDLE);
      idle_wa = run_i[7:0];
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      for (int i = 0; i < NCAM; i++)
        cams[i] <= '0;
    else if (cam_we)
      cams[cam_wa] <= cam_wd;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      for (int i = 0; i < NIDLE; i++)
        idle[i] <= '0;
    else if (idle_we)
      idle[idle_wa] <= idle_wd;
  end

  ////////////////////////////////////////////////////////////////////
  // configuration and read port
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      act_prog <= '0;
      mode     <= MODE_DEF;
      incr     <= 1'b0;
      zero     <= ZERO_DEF;
      scale    <= SCALE_DEF;
      dir      <= DIR_DEF;
    end
    // the end of clear all falls back to delivery defaults synchronously
    else if (restart)
    begin
      act_prog <= '0;
      mode     <= MODE_DEF;
      incr     <= 1'b0;
      zero     <= ZERO_DEF;
      scale    <= SCALE_DEF;
      dir      <= DIR_DEF;
    end
    else
    begin
      if (bus_req.wr && bus_req.addr == A_CTRL)
      begin
        act_prog <= bus_req.wdata[3:0];
        incr     <= bus_req.wdata[CTRL_INCR_BIT];
        if (bus_req.wdata[CTRL_MODE_LSB +: 2] != 2'h0)
          mode <= bus_req.wdata[CTRL_MODE_LSB +: 2];
      end
      if (bus_req.wr && bus_req.addr == A_ZERO && wv < 10'(RES))
        zero <= wv[8:0];
      if (bus_req.wr && bus_req.addr == A_SCALE &&
          bus_req.wdata[13:0] <= SCALE_MAX && bus_req.wdata[31:14] == '0)
        scale <= bus_req.wdata[13:0];
      if (state == S_DIR && confirm)
        dir <= dir_pend;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rd_data                 <= '0;
      pend_on                 <= 1'b0;
      pend_off                <= 1'b0;
      erase_busy              <= 1'b0;
      erase_everything_prompt <= 1'b0;
    end
    else
    begin
      pend_on                 <= state == S_ON;
      pend_off                <= state == S_OFF;
      erase_busy              <= state == S_ERASE;
      erase_everything_prompt <= state == S_ASK;
      rd_data                 <= '0;
      if (bus_req.rd)
        case (bus_req.addr)
          A_CTRL:  rd_data <= 32'({dir, incr, mode, act_prog});
          A_ZERO:  rd_data <= 32'(zero);
          A_SCALE: rd_data <= 32'(scale);
          A_SEL:   rd_data <= 32'({cursor, sel_out, sel_prog});
          A_CMD:   rd_data <= 32'(state);
          A_VAL:   rd_data <= (state == S_SHIFT) ? 32'(shift_amt) :
                              (state == S_DIR) ? 32'(dir_pend) :
                              32'(edit_val);
          A_POS:   rd_data <= 32'(pos);
          A_SPEED: rd_data <= speed_disp;
          A_OUT:   rd_data <= 32'({node_s, cam_out});
          A_CAM:   rd_data <= {shown.valid, 6'h00, shown.off,
                               7'h00, shown.on};
          default: rd_data <= '0;
        endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_edit_go;
    state == S_SHOW && cmd_go && cmd == C_EDIT && rel_s;
  endsequence
  sequence s_erase_go;
    state == S_ASK && confirm;
  endsequence

  new_slot_a: assert property (s_edit_go |=>
    state == S_ON && is_new == !$past(shown.valid))
    else $error("edit entry wrong");
  pending_a: assert property (state == S_OFF |=>
    pend_off && !pend_on) else $error("pending flag wrong");
  teach_load_a: assert property ((state == S_ON || state == S_OFF)
    && teach |=> edit_val == 10'($past(pos)))
    else $error("teach value wrong");
  shift_gate_a: assert property (state == S_SHOW && cmd_go
    && cmd == C_SHIFT |=> (state == S_SHIFT) == $past(rel_s)
    && (state != S_SHIFT || shift_amt == '0))
    else $error("shift entry wrong");
  shift_range_a: assert property (shift_amt < RES)
    else $error("shift out of range");
  shift_end_a: assert property (state == S_SRUN && run_i == CAM_LAST
    |=> state == S_SHOW) else $error("shift not ended");
  erase_busy_a: assert property (s_erase_go |=>
    state == S_ERASE ##1 erase_busy) else $error("erase not busy");
  mode_range_a: assert property (mode != 2'h0)
    else $error("bad compensation mode");
  dir_hold_a: assert property ($changed(dir) |->
    $past(state) == S_DIR || $past(restart))
    else $error("direction changed outside edit");
  scale_range_a: assert property (scale <= SCALE_MAX)
    else $error("scale out of range");
  pos_range_a: assert property (pos < RES)
    else $error("position out of range");

endmodule // cam_switch_programming_core
